/* File: hw/clock_tree_force_map.svh */
// Offsets, field positions, reset values for the clock tree force block.
// Assumes 8-bit configuration registers selected by an 8-bit offset.
`ifndef CLOCK_TREE_FORCE_MAP_SVH
`define CLOCK_TREE_FORCE_MAP_SVH

`define CTF_OFS_DEVICE_ID 8'h20
`define CTF_OFS_DEVICE_REV 8'h21
`define CTF_OFS_DEVICE_MODE 8'h24
`define CTF_OFS_TREE_OVERRIDE 8'h2E
`define CTF_OFS_REG_SLEEP 8'h2F

`define CTF_RST_DEVICE_MODE 8'h04
`define CTF_RST_TREE_OVERRIDE 8'h00
`define CTF_RST_REG_SLEEP 8'h00

`define CTF_BIT_SERIAL_IRQ_MODE 2
`define CTF_BIT_TREE0_OFF 1
`define CTF_BIT_REG_SUSPEND 7
`define CTF_NUM_TREES 4

`endif

/* File: hw/clock_tree_force_pkg.sv */
// Types shared by the clock tree force block.
// Assumes the map header supplies the numeric constants.
package clock_tree_force_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_t;

    typedef enum logic [1:0] {
        PS_ACTIVE = 2'b00,
        PS_HALTED = 2'b01,
        PS_SLEEPING = 2'b11,
        PS_DEEPEST = 2'b10
    } power_state_t;

    typedef struct packed {
        logic serirq_o;
        logic serirq_oe;
        logic clkrun_oe;
        logic dma_clkrun_req;
    } serirq_pins_t;

endpackage

/* File: hw/tree_force_cell.sv */
// One clock tree override cell: force on, force off or automatic gating.
// Assumes the caller registers the result.
`timescale 1ns/10ps
`default_nettype none

module tree_force_cell (
    // Force controls
    input wire logic i_force_on,
    input wire logic i_force_off,
    input wire logic i_force_valid,
    // Automatic gating
    input wire logic i_auto_run,
    output logic o_run
);

    always_comb begin
        if (i_force_valid && i_force_off) begin
            o_run = 1'b0;
        end else if (i_force_valid && i_force_on) begin
            o_run = 1'b1;
        end else begin
            o_run = i_auto_run;
        end
    end

endmodule // tree_force_cell

`default_nettype wire

/* File: hw/clock_tree_force_control.sv */
// Clock tree override registers, regulator suspend select and power state.
// Assumes all inputs synchronous to i_ref_clk and i_reset_n the system reset.
//
// What this block does
// - Override bit 0 forces host tree 0 running and bit 1 forces it stopped.
// - Override bit 2 forces host tree 1 running and bit 3 forces it stopped.
// - Override bit 4 forces the interrupt aggregator tree on, bit 5 off.
// - Override bit 6 forces the GPIO tree on, bit 7 off.
// - While controller tree 0 is stopped, override bits 7 to 4 do nothing.
// - After host tree 0 is forced off the override register is sealed until reset.
// - Regulator bit 7 set suspends the regulator in deepest sleep, clear keeps it on.
// - The serial irq mode bit gates the irq pin, clock-run pin and DMA clock-run effect.
// - The processor sleeping indication feeds the power state decisions.
// - The sleep flag from the clock control register is driven out.
// - A system sleeping state indicator is driven out.
// - Unmapped offsets and reserved bits ignore writes and read as zero.
`timescale 1ns/10ps
`default_nettype none
`include "clock_tree_force_map.svh"

module clock_tree_force_control #(
    parameter int NUM_BLOCKS = 8,
    parameter logic [7:0] DEVICE_ID = 8'hA5, // Arbitrary value
    parameter logic [7:0] DEVICE_REV = 8'h01 // Arbitrary value
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Host index and data ports
    input wire logic i_host_index_wr,
    input wire logic i_host_data_wr,
    input wire logic i_host_data_rd,
    input wire logic [7:0] i_host_wdata,
    // Controller direct access
    input wire clock_tree_force_pkg::cfg_req_t i_ec_req,
    // Read answer
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    // Clock trees
    input wire logic [`CTF_NUM_TREES-1:0] i_tree_auto_run,
    input wire logic i_ec_tree0_running,
    output logic [`CTF_NUM_TREES-1:0] o_tree_run,
    output logic o_override_locked,
    // Power state
    input wire logic i_cpu_sleeping_indication,
    input wire logic i_clk_ctrl_sleep,
    input wire logic [NUM_BLOCKS-1:0] i_clock_required,
    output logic o_sleep_flag,
    output logic o_sleep_state,
    output clock_tree_force_pkg::power_state_t o_power_state,
    output logic o_regulator_suspend,
    // Serial irq and clock-run
    input wire logic i_serirq_drive,
    input wire logic i_serirq_drive_oe,
    input wire logic i_clkrun_drive_oe,
    input wire logic i_dma_clkrun_req,
    output logic o_serial_irq_mode,
    output clock_tree_force_pkg::serirq_pins_t o_pins
);
    import clock_tree_force_pkg::*;

    cfg_req_t acc;
    logic [7:0] index_reg;
    logic [7:0] next_index_reg;
    logic [7:0] override_reg;
    logic [7:0] next_override_reg;
    logic locked;
    logic next_locked;
    logic serial_irq_mode_bit;
    logic next_serial_irq_mode_bit;
    logic reg_suspend_sel;
    logic next_reg_suspend_sel;
    logic [7:0] next_rdata;
    logic next_rdata_valid;
    logic [`CTF_NUM_TREES-1:0] tree_run_raw;
    logic [`CTF_NUM_TREES-1:0] force_valid;
    power_state_t state;
    power_state_t next_state;
    logic next_sleep_flag;
    logic next_reg_suspend;
    serirq_pins_t next_pins;

    // Controller access wins a same-cycle clash; host data uses the index
    always_comb begin
        if (i_ec_req.wr || i_ec_req.rd) begin
            acc = i_ec_req;
        end else begin
            acc.wr = i_host_data_wr;
            acc.rd = i_host_data_rd;
            acc.addr = index_reg;
            acc.wdata = i_host_wdata;
        end
    end

    // Register file
    always_comb begin
        next_index_reg = index_reg;
        next_override_reg = override_reg;
        next_locked = locked;
        next_serial_irq_mode_bit = serial_irq_mode_bit;
        next_reg_suspend_sel = reg_suspend_sel;
        if (i_host_index_wr) begin
            next_index_reg = i_host_wdata;
        end
        if (acc.wr) begin
            unique case (acc.addr)
                `CTF_OFS_TREE_OVERRIDE: begin
                    if (!locked) begin
                        next_override_reg = acc.wdata;
                        next_locked = acc.wdata[`CTF_BIT_TREE0_OFF];
                    end
                end
                `CTF_OFS_DEVICE_MODE: begin
                    next_serial_irq_mode_bit = acc.wdata[`CTF_BIT_SERIAL_IRQ_MODE];
                end
                `CTF_OFS_REG_SLEEP: begin
                    next_reg_suspend_sel = acc.wdata[`CTF_BIT_REG_SUSPEND];
                end
                default: begin
                    next_locked = locked;
                end
            endcase
        end
    end

    // Read answer, reserved bits and holes read zero
    always_comb begin
        next_rdata = 8'h00;
        next_rdata_valid = acc.rd;
        if (acc.rd) begin
            unique case (acc.addr)
                `CTF_OFS_DEVICE_ID: next_rdata = DEVICE_ID;
                `CTF_OFS_DEVICE_REV: next_rdata = DEVICE_REV;
                `CTF_OFS_DEVICE_MODE: begin
                    next_rdata[`CTF_BIT_SERIAL_IRQ_MODE] = serial_irq_mode_bit;
                end
                `CTF_OFS_TREE_OVERRIDE: begin
                    // Sealed register answers zero; reads are blocked too
                    next_rdata = locked ? 8'h00 : override_reg;
                end
                `CTF_OFS_REG_SLEEP: begin
                    next_rdata[`CTF_BIT_REG_SUSPEND] = reg_suspend_sel;
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            index_reg <= 8'h00;
            override_reg <= `CTF_RST_TREE_OVERRIDE;
            locked <= 1'b0;
            serial_irq_mode_bit <= 1'(`CTF_RST_DEVICE_MODE >> `CTF_BIT_SERIAL_IRQ_MODE);
            reg_suspend_sel <= 1'(`CTF_RST_REG_SLEEP >> `CTF_BIT_REG_SUSPEND);
            o_rdata <= 8'h00;
            o_rdata_valid <= 1'b0;
        end else begin
            index_reg <= next_index_reg;
            override_reg <= next_override_reg;
            locked <= next_locked;
            serial_irq_mode_bit <= next_serial_irq_mode_bit;
            reg_suspend_sel <= next_reg_suspend_sel;
            o_rdata <= next_rdata;
            o_rdata_valid <= next_rdata_valid;
        end
    end

    // Upper trees depend on the controller tree for their override path
    assign force_valid = {{2{i_ec_tree0_running}}, 2'b11};

    genvar t;
    generate
        for (t = 0; t < `CTF_NUM_TREES; t++) begin : g_tree
            tree_force_cell u_cell (
                .i_force_on(override_reg[2*t]),
                .i_force_off(override_reg[2*t+1]),
                .i_force_valid(force_valid[t]),
                .i_auto_run(i_tree_auto_run[t]),
                .o_run(tree_run_raw[t])
            );
        end
    endgenerate

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tree_run <= '0;
        end else begin
            o_tree_run <= tree_run_raw;
        end
    end

    assign o_override_locked = locked;
    assign o_serial_irq_mode = serial_irq_mode_bit;

    // Power state; deepest sleep needs every block to release its clock
    always_comb begin
        next_state = state;
        unique case (state)
            PS_ACTIVE: begin
                if (i_cpu_sleeping_indication) next_state = PS_HALTED;
            end
            PS_HALTED: begin
                if (!i_cpu_sleeping_indication) next_state = PS_ACTIVE;
                else if (o_sleep_flag) next_state = PS_SLEEPING;
            end
            PS_SLEEPING: begin
                if (!i_cpu_sleeping_indication || !o_sleep_flag) begin
                    next_state = PS_ACTIVE;
                end else if (i_clock_required == '0) begin
                    next_state = PS_DEEPEST;
                end
            end
            PS_DEEPEST: begin
                if (!i_cpu_sleeping_indication || !o_sleep_flag ||
                    i_clock_required != '0) begin
                    next_state = PS_ACTIVE;
                end
            end
        endcase
        next_sleep_flag = i_clk_ctrl_sleep;
        next_reg_suspend = reg_suspend_sel && (state == PS_DEEPEST);
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= PS_ACTIVE;
            o_sleep_flag <= 1'b0;
            o_regulator_suspend <= 1'b0;
        end else begin
            state <= next_state;
            o_sleep_flag <= next_sleep_flag;
            o_regulator_suspend <= next_reg_suspend;
        end
    end

    // Both sleeping codes share the upper bit
    assign o_sleep_state = state[1];
    assign o_power_state = state;

    // Serial irq and clock-run pin gating
    always_comb begin
        next_pins.serirq_o = i_serirq_drive;
        next_pins.serirq_oe = serial_irq_mode_bit && i_serirq_drive_oe;
        next_pins.clkrun_oe = serial_irq_mode_bit && i_clkrun_drive_oe;
        next_pins.dma_clkrun_req = serial_irq_mode_bit && i_dma_clkrun_req;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pins <= '0;
        end else begin
            o_pins <= next_pins;
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_sleep_held;
        i_cpu_sleeping_indication && o_sleep_flag [*3];
    endsequence

    sequence s_ovr_write;
        acc.wr && acc.addr == `CTF_OFS_TREE_OVERRIDE;
    endsequence

    chk_tree0_on: assert property (
        override_reg[0] && !override_reg[1] |=> o_tree_run[0])
        else $error("tree 0 not forced on");
    chk_tree0_off_wins: assert property (
        override_reg[1] |=> !o_tree_run[0])
        else $error("tree 0 not forced off");
    chk_tree1_force: assert property (
        override_reg[3] || override_reg[2] |=> o_tree_run[1] == !$past(override_reg[3]))
        else $error("tree 1 force wrong");
    chk_upper_forced: assert property (
        i_ec_tree0_running && override_reg[5] |=> !o_tree_run[2])
        else $error("aggregator tree not forced off");
    chk_gpio_forced: assert property (
        i_ec_tree0_running && override_reg[6] && !override_reg[7] |=> o_tree_run[3])
        else $error("gpio tree not forced on");
    chk_upper_ignored: assert property (
        !i_ec_tree0_running |=> o_tree_run[3:2] == $past(i_tree_auto_run[3:2]))
        else $error("upper force bits acted while tree 0 stopped");
    chk_auto_gate: assert property (
        override_reg[3:2] == 2'b00 |=> o_tree_run[1] == $past(i_tree_auto_run[1]))
        else $error("tree 1 left automatic gating");
    chk_lock_sets: assert property (
        s_ovr_write ##0 (!locked && acc.wdata[1]) |=> locked [*3])
        else $error("override not sealed after tree 0 off");
    chk_lock_holds: assert property (
        locked ##0 s_ovr_write |=> override_reg == $past(override_reg) && locked)
        else $error("sealed override changed");
    chk_hole_reads: assert property (
        acc.rd && acc.addr[7:5] == 3'b000 |=> o_rdata_valid && o_rdata == 8'h00)
        else $error("hole read not zero");
    chk_reg_suspend: assert property (
        state == PS_DEEPEST && reg_suspend_sel |=> o_regulator_suspend)
        else $error("regulator not suspended in deepest sleep");
    chk_reg_awake: assert property (
        state == PS_ACTIVE |=> !o_regulator_suspend)
        else $error("regulator suspended while active");
    chk_sleep_entry: assert property (
        state == PS_ACTIVE ##0 s_sleep_held |=> o_sleep_state)
        else $error("sleep state not reached");
    chk_wake: assert property (
        !i_cpu_sleeping_indication |=> state == PS_ACTIVE && !o_sleep_state)
        else $error("no wake on processor running");
    chk_sleep_flag: assert property (
        $rose(i_clk_ctrl_sleep) |=> o_sleep_flag)
        else $error("sleep flag not driven");
    chk_serirq_off: assert property (
        !serial_irq_mode_bit |=> !o_pins.serirq_oe && !o_pins.clkrun_oe && !o_pins.dma_clkrun_req)
        else $error("serial irq pins active while disabled");

endmodule // clock_tree_force_control

`default_nettype wire

/* File: testbench/tb.sv */
// Testbench for the clock tree force block: registers, trees, power state.
// Assumes one 100 MHz clock and the async active-low system reset.
`timescale 1ns/10ps
`default_nettype none
`include "clock_tree_force_map.svh"

module tb;
    import clock_tree_force_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary value
    localparam logic [7:0] OVR = `CTF_OFS_TREE_OVERRIDE;
    localparam logic [7:0] RSL = `CTF_OFS_REG_SLEEP;
    localparam logic [7:0] MODE = `CTF_OFS_DEVICE_MODE;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic idx_wr = 1'b0;
    logic dat_wr = 1'b0;
    logic dat_rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    cfg_req_t ec = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] auto_run = 4'h0;
    logic ec_t0 = 1'b1;
    logic [3:0] run;
    logic locked;
    logic cpu = 1'b0;
    logic csleep = 1'b0;
    logic [7:0] req = 8'hFF;
    logic sflag;
    logic sstate;
    power_state_t ps;
    logic vsus;
    logic sdrv = 1'b0;
    logic soe = 1'b0;
    logic coe = 1'b0;
    logic dreq = 1'b0;
    logic smode;
    serirq_pins_t pins;
    int err_count = 0;
    int num_checks = 0;

    clock_tree_force_control #(.DEVICE_ID(ID_VAL)) u_clock_tree_force_control (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_host_index_wr(idx_wr),
        .i_host_data_wr(dat_wr), .i_host_data_rd(dat_rd), .i_host_wdata(wdata),
        .i_ec_req(ec), .o_rdata(rdata), .o_rdata_valid(rvalid),
        .i_tree_auto_run(auto_run), .i_ec_tree0_running(ec_t0), .o_tree_run(run),
        .o_override_locked(locked), .i_cpu_sleeping_indication(cpu),
        .i_clk_ctrl_sleep(csleep), .i_clock_required(req), .o_sleep_flag(sflag),
        .o_sleep_state(sstate), .o_power_state(ps), .o_regulator_suspend(vsus),
        .i_serirq_drive(sdrv), .i_serirq_drive_oe(soe), .i_clkrun_drive_oe(coe),
        .i_dma_clkrun_req(dreq), .o_serial_irq_mode(smode), .o_pins(pins));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Index first, data port after
    task automatic host_acc(input logic [7:0] ofs, input logic [7:0] d, input logic rd);
        @(posedge clk);
        idx_wr <= 1'b1;
        wdata <= ofs;
        @(posedge clk);
        idx_wr <= 1'b0;
        dat_wr <= ~rd;
        dat_rd <= rd;
        wdata <= d;
        @(posedge clk);
        dat_wr <= 1'b0;
        dat_rd <= 1'b0;
        #1;
    endtask

    task automatic host_rd(input logic [7:0] ofs, input logic [7:0] exp);
        host_acc(ofs, 8'h00, 1'b1);
        check("host read data", rdata, exp);
        check("host read valid", {7'h00, rvalid}, 8'h01);
    endtask

    task automatic ec_acc(input logic [7:0] a, input logic [7:0] d, input logic rd);
        @(posedge clk);
        ec <= '{wr: ~rd, rd: rd, addr: a, wdata: d};
        @(posedge clk);
        ec <= '0;
        #1;
    endtask

    task automatic ec_rd(input logic [7:0] a, input logic [7:0] exp);
        ec_acc(a, 8'h00, 1'b1);
        check("ec read data", rdata, exp);
        check("ec read valid", {7'h00, rvalid}, 8'h01);
    endtask

    task automatic test_regs();
        ec_rd(`CTF_OFS_DEVICE_ID, ID_VAL);
        ec_rd(MODE, `CTF_RST_DEVICE_MODE);
        host_rd(OVR, `CTF_RST_TREE_OVERRIDE);
        host_rd(RSL, `CTF_RST_REG_SLEEP);
        ec_acc(8'h30, 8'hFF, 1'b0);
        ec_rd(8'h30, 8'h00);
        ec_rd(8'h07, 8'h00);
        ec_acc(`CTF_OFS_DEVICE_ID, 8'h00, 1'b0);
        ec_rd(`CTF_OFS_DEVICE_ID, ID_VAL);
        host_acc(MODE, 8'hFF, 1'b0);
        host_rd(MODE, 8'h04);
        host_acc(RSL, 8'hFF, 1'b0);
        host_rd(RSL, 8'h80);
        @(posedge clk);
        #1;
        check("valid one cycle", {7'h00, rvalid}, 8'h00);
        ec_acc(RSL, 8'h00, 1'b0);
        $display("test_regs done");
    endtask

    // Pin enables and DMA clock-run request follow the engines only while serial irq mode is set; serirq_o always follows
    task automatic test_pins();
        @(posedge clk);
        {sdrv, soe, coe, dreq} <= 4'hF;
        repeat (2) @(posedge clk);
        #1;
        check("pins enabled", {4'h0, pins}, 8'h0F);
        ec_acc(MODE, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check("mode bit", {7'h00, smode}, 8'h00);
        check("pins gated", {5'h00, pins.serirq_oe, pins.clkrun_oe, pins.dma_clkrun_req}, 8'h00);
        ec_acc(MODE, 8'h04, 1'b0);
        $display("test_pins done");
    endtask

    task automatic tree_case(input logic [7:0] ov, input logic [3:0] au, input logic t0,
                             input logic [3:0] exp);
        @(posedge clk);
        auto_run <= au;
        ec_t0 <= t0;
        host_acc(OVR, ov, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check("tree run", {4'h0, run}, {4'h0, exp});
    endtask

    task automatic test_trees();
        tree_case(8'h00, 4'hA, 1'b1, 4'hA);
        tree_case(8'h55, 4'h0, 1'b1, 4'hF);
        tree_case(8'hA8, 4'hF, 1'b1, 4'h1);
        tree_case(8'hFC, 4'hF, 1'b1, 4'h1);
        tree_case(8'hA8, 4'hF, 1'b0, 4'hD);
        tree_case(8'h55, 4'h0, 1'b0, 4'h3);
        tree_case(8'h03, 4'hF, 1'b1, 4'hE);
        check("locked", {7'h00, locked}, 8'h01);
        tree_case(8'h00, 4'hF, 1'b1, 4'hE);
        host_rd(OVR, 8'h00);
        do_reset();
        @(posedge clk);
        #1;
        check("unlocked", {7'h00, locked}, 8'h00);
        host_acc(OVR, 8'h01, 1'b0);
        ec_rd(OVR, 8'h01);
        host_acc(OVR, 8'h00, 1'b0);
        $display("test_trees done");
    endtask

    task automatic wait_ps(input power_state_t st);
        int n;
        n = 0;
        while (ps !== st && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("power state", {6'h00, ps}, {6'h00, st});
    endtask

    task automatic test_power();
        ec_acc(RSL, 8'h80, 1'b0);
        @(posedge clk);
        cpu <= 1'b1;
        wait_ps(PS_HALTED);
        @(posedge clk);
        csleep <= 1'b1;
        @(posedge clk);
        #1;
        check("sleep flag", {7'h00, sflag}, 8'h01);
        wait_ps(PS_SLEEPING);
        check("sleep state", {7'h00, sstate}, 8'h01);
        check("no suspend", {7'h00, vsus}, 8'h00);
        @(posedge clk);
        req <= 8'h00;
        wait_ps(PS_DEEPEST);
        @(posedge clk);
        #1;
        check("suspend", {7'h00, vsus}, 8'h01);
        ec_acc(RSL, 8'h00, 1'b0);
        @(posedge clk);
        #1;
        check("kept powered", {7'h00, vsus}, 8'h00);
        @(posedge clk);
        req <= 8'h01;
        wait_ps(PS_ACTIVE);
        check("awake state", {7'h00, sstate}, 8'h00);
        @(posedge clk);
        cpu <= 1'b0;
        req <= 8'hFF;
        repeat (2) @(posedge clk);
        #1;
        check("woken", {6'h00, ps}, {6'h00, PS_ACTIVE});
        // Sleep flag already up, so the processor alone walks into sleep
        @(posedge clk);
        cpu <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("sleep entry", {7'h00, sstate}, 8'h01);
        @(posedge clk);
        cpu <= 1'b0;
        csleep <= 1'b0;
        $display("test_power done");
    endtask

    initial begin
        #100us;
        err_count++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        do_reset();
        test_regs();
        test_pins();
        test_trees();
        test_power();
        stop_test();
    end
endmodule // tb
`default_nettype wire
